// File: rtl/p7gpio_consts.vh
// Constants for the eight-bit general-purpose port with register access over AXI4-Lite.
`ifndef P7GPIO_CONSTS_VH
`define P7GPIO_CONSTS_VH

// Register indices; the byte address of each register is four times its index.
`define P7G_IDX_W 16
`define P7G_IDX_LATCH 16'hFFDA
`define P7G_IDX_DIR 16'hFFEA
`define P7G_IDX_LCDCTL 16'hFFC0

// Reset values.
`define P7G_RST_LATCH 8'h00
`define P7G_RST_DIR 8'h00
`define P7G_RST_LCDCTL 4'h0

// Read values and field layout.
`define P7G_DIR_READ 8'hFF
`define P7G_SGS_W 4
`define P7G_SGS_MSB 3
`define P7G_SGS_HI_MSB 3
`define P7G_SGS_HI_LSB 2
`define P7G_SGS_HI_IO 2'h0
`define P7G_SGS_LO_IO 1'h0
`define P7G_PIN_SPLIT 4

// AXI4-Lite response codes and bus widths.
`define P7G_RESP_OKAY 2'h0
`define P7G_RESP_SLVERR 2'h2
`define P7G_DATA_W 32
`define P7G_STRB_W 4
`define P7G_LANE0 0
`define P7G_WORD_LSB 2
`define P7G_ZERO32 32'h00000000

`endif

// File: rtl/p7gpio_reg8.v
// Resettable register with a write enable, used for each software-visible setting.
`default_nettype none

module p7gpio_reg8 #(
    parameter WIDTH = 8,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    input wire aclk,
    input wire aresetn,
    input wire we,
    input wire [WIDTH-1:0] d,
    output reg [WIDTH-1:0] q_r
);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q_r <= RESET_VALUE;
        end
        else if (we)
        begin
            q_r <= d;
        end
    end

endmodule

`default_nettype wire

// File: rtl/p7gpio_pin_cell.v
// Output stage of one port pin: drive value, driver enable and read-back bit.
`default_nettype none

module p7gpio_pin_cell (
    input wire aclk,
    input wire aresetn,
    input wire gpio_sel,
    input wire dir_out,
    input wire latch_bit,
    input wire pin_in,
    output wire rd_bit,
    output reg pin_out_r,
    output reg pin_oe_n_r
);

    // Output-direction bits return the latch, input-direction bits the pin.
    assign rd_bit = dir_out ? latch_bit : pin_in;

    // The enable is low while the pin is driven; a segment pin leaves it to the LCD side.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_out_r <= 1'b0;
            pin_oe_n_r <= 1'b1;
        end
        else
        begin
            pin_out_r <= gpio_sel & dir_out & latch_bit;
            pin_oe_n_r <= ~(gpio_sel & dir_out);
        end
    end

endmodule

`default_nettype wire

// File: rtl/p7gpio_top.v
// Eight-bit general-purpose port with AXI4-Lite register access and LCD pin sharing.
`include "p7gpio_consts.vh"
`default_nettype none

module p7gpio_top #(
    parameter ADDR_W = 18,
    parameter NPINS = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [`P7G_DATA_W-1:0] s_axi_wdata,
    input wire [`P7G_STRB_W-1:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [`P7G_DATA_W-1:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [NPINS-1:0] port_pin_in,
    output wire [NPINS-1:0] port_pin_out,
    output wire [NPINS-1:0] port_pin_oe_n,
    output wire [`P7G_SGS_W-1:0] segment_select_field
);

    // Write channel state.
    reg aw_held_r;
    reg [ADDR_W-1:0] aw_addr_r;
    reg w_held_r;
    reg [`P7G_DATA_W-1:0] w_data_r;
    reg [`P7G_STRB_W-1:0] w_strb_r;

    // Register contents.
    wire [NPINS-1:0] port_output_latch;
    wire [NPINS-1:0] port_direction;
    wire [`P7G_SGS_W-1:0] lcd_port_control;

    // Per-pin signals.
    wire [NPINS-1:0] gpio_sel;
    wire [NPINS-1:0] port_read;

    // Write decode.
    wire aw_take;
    wire w_take;
    wire wr_go;
    wire wr_lane0;
    wire [`P7G_IDX_W-1:0] wr_idx;
    wire wr_hit_latch;
    wire wr_hit_dir;
    wire wr_hit_lcd;
    wire wr_mapped;

    // Read decode.
    wire ar_take;
    wire [`P7G_IDX_W-1:0] rd_idx;
    reg [`P7G_DATA_W-1:0] rd_data_nxt;
    reg [1:0] rd_resp_nxt;

    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;
    assign wr_lane0 = w_strb_r[`P7G_LANE0];

    assign wr_idx = aw_addr_r[ADDR_W-1:`P7G_WORD_LSB];
    assign wr_hit_latch = (wr_idx == `P7G_IDX_LATCH);
    assign wr_hit_dir = (wr_idx == `P7G_IDX_DIR);
    assign wr_hit_lcd = (wr_idx == `P7G_IDX_LCDCTL);
    assign wr_mapped = wr_hit_latch | wr_hit_dir | wr_hit_lcd;

    // Address and data are caught in either order and held until both are present.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            aw_addr_r <= {ADDR_W{1'b0}};
            s_axi_awready <= 1'b1;
        end
        else if (aw_take)
        begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        else if (wr_go)
        begin
            aw_held_r <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_awready <= 1'b1;
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_r <= 1'b0;
            w_data_r <= `P7G_ZERO32;
            w_strb_r <= {`P7G_STRB_W{1'b0}};
            s_axi_wready <= 1'b1;
        end
        else if (w_take)
        begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        else if (wr_go)
        begin
            w_held_r <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_wready <= 1'b1;
        end
    end

    // The response is raised on the same edge as the register update.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `P7G_RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? `P7G_RESP_OKAY : `P7G_RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    p7gpio_reg8 #(
        .WIDTH(NPINS),
        .RESET_VALUE(`P7G_RST_LATCH)
    ) u_latch (
        .aclk(aclk),
        .aresetn(aresetn),
        .we(wr_go & wr_hit_latch & wr_lane0),
        .d(w_data_r[NPINS-1:0]),
        .q_r(port_output_latch)
    );

    p7gpio_reg8 #(
        .WIDTH(NPINS),
        .RESET_VALUE(`P7G_RST_DIR)
    ) u_dir (
        .aclk(aclk),
        .aresetn(aresetn),
        .we(wr_go & wr_hit_dir & wr_lane0),
        .d(w_data_r[NPINS-1:0]),
        .q_r(port_direction)
    );

    p7gpio_reg8 #(
        .WIDTH(`P7G_SGS_W),
        .RESET_VALUE(`P7G_RST_LCDCTL)
    ) u_lcdctl (
        .aclk(aclk),
        .aresetn(aresetn),
        .we(wr_go & wr_hit_lcd & wr_lane0),
        .d(w_data_r[`P7G_SGS_W-1:0]),
        .q_r(lcd_port_control)
    );

    assign segment_select_field = lcd_port_control;

    // Upper pins are general I/O only with the top two select bits clear,
    // lower pins whenever the top select bit is clear.
    genvar n;
    generate
        for (n = 0; n < NPINS; n = n + 1)
        begin : g_pin
            if (n >= `P7G_PIN_SPLIT)
            begin : g_hi
                assign gpio_sel[n] = (lcd_port_control[`P7G_SGS_HI_MSB:`P7G_SGS_HI_LSB]
                    == `P7G_SGS_HI_IO);
            end
            else
            begin : g_lo
                assign gpio_sel[n] = (lcd_port_control[`P7G_SGS_MSB]
                    == `P7G_SGS_LO_IO);
            end

            p7gpio_pin_cell u_cell (
                .aclk(aclk),
                .aresetn(aresetn),
                .gpio_sel(gpio_sel[n]),
                .dir_out(port_direction[n]),
                .latch_bit(port_output_latch[n]),
                .pin_in(port_pin_in[n]),
                .rd_bit(port_read[n]),
                .pin_out_r(port_pin_out[n]),
                .pin_oe_n_r(port_pin_oe_n[n])
            );
        end
    endgenerate

    // Read path: one read at a time, answered the cycle after the address is taken.
    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign rd_idx = s_axi_araddr[ADDR_W-1:`P7G_WORD_LSB];

    always @*
    begin
        rd_data_nxt = `P7G_ZERO32;
        rd_resp_nxt = `P7G_RESP_OKAY;
        if (rd_idx == `P7G_IDX_LATCH)
        begin
            rd_data_nxt[NPINS-1:0] = port_read;
        end
        else if (rd_idx == `P7G_IDX_DIR)
        begin
            rd_data_nxt[NPINS-1:0] = `P7G_DIR_READ;
        end
        else if (rd_idx == `P7G_IDX_LCDCTL)
        begin
            rd_data_nxt[`P7G_SGS_W-1:0] = lcd_port_control;
        end
        else
        begin
            rd_resp_nxt = `P7G_RESP_SLVERR;
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `P7G_ZERO32;
            s_axi_rresp <= `P7G_RESP_OKAY;
        end
        else if (ar_take)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data_nxt;
            s_axi_rresp <= rd_resp_nxt;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// File: verif/p7gpio_pins.sv
// Pin model: drives undriven pins from outside, driven pins follow the port.
`default_nettype none
module p7gpio_pins (
    input wire logic [7:0] drv,
    input wire logic [7:0] oe_n,
    input wire logic [7:0] ext,
    output logic [7:0] lvl
);
    timeunit 1ns;
    timeprecision 1ns;
    assign lvl = (drv & ~oe_n) | (ext & oe_n);
endmodule
`default_nettype wire

// File: verif/p7gpio_chk_assertions.sv
// Concurrent checks on the port's bus answers and pin drive.
`include "p7gpio_consts.vh"
`default_nettype none
module p7gpio_chk #(
    parameter ADDR_W = 18,
    parameter NPINS = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic [NPINS-1:0] port_pin_in,
    input wire logic [NPINS-1:0] port_pin_out,
    input wire logic [NPINS-1:0] port_pin_oe_n,
    input wire logic [3:0] segment_select_field
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic aw_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire logic ar_go = s_axi_arvalid && s_axi_arready;
    wire logic [15:0] ridx = s_axi_araddr[ADDR_W-1:2];
    function automatic logic hit(input logic [15:0] i);
        return i == `P7G_IDX_LATCH || i == `P7G_IDX_DIR || i == `P7G_IDX_LCDCTL;
    endfunction
    AST_WR_RESP: assert property (aw_go |-> ##2 s_axi_bvalid &&
        s_axi_bresp == (hit($past(s_axi_awaddr[ADDR_W-1:2], 2)) ? 2'h0 : 2'h2))
        else $error("bad bresp");
    AST_RD_UNMAP: assert property (ar_go && !hit(ridx) |=> s_axi_rvalid &&
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("bad unmapped read");
    AST_DIR_RD: assert property (ar_go && ridx == `P7G_IDX_DIR |=>
        s_axi_rdata == 32'h000000FF) else $error("direction read not all ones");
    AST_RD_UPPER: assert property (ar_go |=> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_MIX_RD: assert property (ar_go && ridx == `P7G_IDX_LATCH &&
        segment_select_field == 4'h0 && s_axi_awready && !s_axi_bvalid |=> s_axi_rdata[7:0] ==
        ($past(port_pin_out) | ($past(port_pin_in) & $past(port_pin_oe_n))))
        else $error("data read mixes wrong");
    AST_HI_SEL: assert property (port_pin_oe_n[7:4] != 4'hF |->
        $past(segment_select_field[3:2]) == 2'h0) else $error("upper pins driven unselected");
    AST_LO_SEL: assert property (port_pin_oe_n[3:0] != 4'hF |->
        !$past(segment_select_field[3])) else $error("lower pins driven unselected");
    AST_UNDRV: assert property ((port_pin_out & port_pin_oe_n) == '0)
        else $error("undriven pin shows data");
    AST_RESET: assert property (disable iff (1'b0) !aresetn |=>
        port_pin_oe_n == 8'hFF && port_pin_out == 8'h00 && segment_select_field == 4'h0)
        else $error("reset state wrong");
    AST_WR_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while busy");
    AST_RD_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while busy");
endmodule
`default_nettype wire

// File: verif/p7gpio_top_tb_top.sv
// Testbench for the port: register access, read-back mixing and pin drive.
`default_nettype none
module p7gpio_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [17:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0] s_axi_wstrb = 4'h1, fld = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [7:0] ext = 8'h5A, dir, sel;
    logic [15:0] rs = 16'h0011;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [7:0] port_pin_in, port_pin_out, port_pin_oe_n;
    wire logic [3:0] segment_select_field;
    logic [34:0] q[$];
    logic [34:0] e;
    logic [7:0] lat = 8'h00;
    int miscompares = 0, checks_done = 0;
    p7gpio_top dut (.*);
    p7gpio_pins pins_m (.drv(port_pin_out), .oe_n(port_pin_oe_n), .ext(ext), .lvl(port_pin_in));
    initial forever #50 aclk = ~aclk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input string n, input logic [34:0] x, input logic [34:0] s);
        checks_done++;
        if (x !== s)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, x, s);
        end
    endtask
    always @(posedge aclk)
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
        begin
            e = q.pop_front();
            chk("response", e, s_axi_rvalid ? {1'h1, s_axi_rresp, s_axi_rdata}
                : {1'h0, s_axi_bresp, 32'h0});
        end
    task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [1:0] r);
        logic ta, tw;
        ta = 1'h0;
        tw = 1'h0;
        q.push_back({1'h0, r, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(ta && tw))
        begin
            @(posedge aclk);
            ta = ta | s_axi_awready;
            tw = tw | s_axi_wready;
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
    endtask
    task automatic rd(input logic [17:0] a, input logic [31:0] x, input logic [1:0] r);
        q.push_back({1'h1, r, x});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
    endtask
    task automatic pins;
        sel = {{4{fld[3:2] == 2'h0}}, {4{!fld[3]}}};
        chk("oe_n", 8'(~(sel & dir)), port_pin_oe_n);
        chk("pin_out", 8'(sel & dir & lat), port_pin_out);
        chk("select", fld, segment_select_field);
    endtask
    task automatic step(input logic [7:0] l, input logic [7:0] d, input logic [3:0] f);
        dir = d;
        fld = f;
        wr(18'h3FF00, {4'h0, f}, 2'h0);
        wr(18'h3FFA8, d, 2'h0);
        wr(18'h3FF68, l, 2'h0);
        rd(18'h3FFA8, 32'h000000FF, 2'h0);
        rd(18'h3FF68, {24'h0, (d & l) | (~d & ext)}, 2'h0);
        lat = l;
        pins;
    endtask
    task automatic rst;
        aresetn <= 1'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        dir = 8'h00;
        fld = 4'h0;
        lat = 8'h00;
        pins;
        rd(18'h3FF68, {24'h0, ext}, 2'h0);
        wr(18'h3FFA8, 8'hFF, 2'h0);
        rd(18'h3FF68, 32'h0, 2'h0);
    endtask
    task automatic summarize;
        if (miscompares == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        rst;
        wr(18'h00010, 8'h3C, 2'h2);
        rd(18'h00010, 32'h0, 2'h2);
        s_axi_wstrb <= 4'h0;
        wr(18'h3FF68, 8'hFF, 2'h0);
        s_axi_wstrb <= 4'h1;
        rd(18'h3FF68, 32'h0, 2'h0);
        step(8'hA5, 8'hFF, 4'h0);
        step(8'hFF, 8'h0F, 4'h4);
        step(8'h3C, 8'hF0, 4'h8);
        repeat (12)
        begin
            rs = lfsr(rs);
            ext <= rs[7:0];
            rs = lfsr(lfsr(rs));
            step(rs[15:8], rs[7:0], rs[3:0] & 4'h7);
        end
        rst;
        summarize;
    end
    initial
    begin
        repeat (5000) @(posedge aclk);
        miscompares++;
        summarize;
    end
endmodule
bind p7gpio_top p7gpio_chk #(.ADDR_W(ADDR_W), .NPINS(NPINS)) u_chk (.*);
`default_nettype wire
